// *** pcr_chan.sv ***
`timescale 1ns/10ps
`include "pcr_map.svh"

module pcr_chan
    import pcr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    pcr_chan_if.chan cb
);
    pcr_chan_state_t s_q;
    pcr_chan_state_t s_d;
    logic pin_on;
    logic want;
    logic [3:0] mrg;

    always_comb begin
        s_d = s_q;
        pin_on = cb.pol ? cb.pin : ~cb.pin;
        // Start gating from pin and command
        want = cb.power_ok
            & (~cb.cfg[`PCR_CFG_PU]
            | ((~cb.cfg[`PCR_CFG_CMD] | cb.op[`PCR_OP_ON])
            & (~cb.cfg[`PCR_CFG_CPR] | pin_on)));
        // Latch released only by removing the enable
        s_d.latched = cb.fault_shutdown | (s_q.latched & want);
        unique case (s_q.st)
            PCR_OFF: begin
                if (want && !s_q.latched && !cb.fault) begin
                    s_d.st = PCR_RUN;
                end
            end
            PCR_RUN: begin
                if (cb.fault_shutdown) begin
                    s_d.st = PCR_OFF;
                end else if (!want) begin
                    s_d.cnt = cb.off_delay;
                    s_d.st = (cb.off_delay == '0) ? PCR_OFF : PCR_STOP;
                end
            end
            PCR_STOP: begin
                if (cb.fault_shutdown) begin
                    s_d.st = PCR_OFF;
                end else if (want) begin
                    s_d.st = PCR_RUN;
                end else if (s_q.cnt <= 16'h0001) begin
                    s_d.st = PCR_OFF;
                end else begin
                    s_d.cnt = s_q.cnt - 16'h0001;
                end
            end
            default: s_d.st = PCR_OFF;
        endcase
        mrg = cb.op[`PCR_OP_MRG_HI:`PCR_OP_MRG_LO];
        s_d.act_flt = (mrg == `PCR_MRG_LO_ACT) || (mrg == `PCR_MRG_HI_ACT);
        if (mrg == `PCR_MRG_LO_IGN || mrg == `PCR_MRG_LO_ACT) begin
            s_d.vsel = `PCR_VSEL_LOW;
        end else if (mrg == `PCR_MRG_HI_IGN || mrg == `PCR_MRG_HI_ACT) begin
            s_d.vsel = `PCR_VSEL_HIGH;
        end else begin
            s_d.vsel = `PCR_VSEL_NOM;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '{st: PCR_OFF, cnt: '0, latched: 1'b0,
                vsel: `PCR_VSEL_NOM, act_flt: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // Both gate drivers low only when off; held on through the delayed stop
    assign cb.run = (s_q.st != PCR_OFF);
    assign cb.vsel = s_q.vsel;
    assign cb.act_flt = s_q.act_flt;
endmodule // pcr_chan

// *** pcr_chan_if.sv ***
`timescale 1ns/10ps

interface pcr_chan_if;
    logic [7:0] op;
    logic [7:0] cfg;
    logic pol;
    logic pin;
    logic power_ok;
    logic fault;
    logic fault_shutdown;
    pcr_pkg::pcr_dly_t off_delay;
    logic run;
    logic [1:0] vsel;
    logic act_flt;

    modport ctl (
        output op, cfg, pol, pin, power_ok, fault, fault_shutdown,
        output off_delay,
        input run, vsel, act_flt
    );
    modport chan (
        input op, cfg, pol, pin, power_ok, fault, fault_shutdown,
        input off_delay,
        output run, vsel, act_flt
    );
endinterface

// *** pcr_host_model.sv ***
`timescale 1ns/10ps

module pcr_host_model (
    input wire logic clk,
    input wire logic cmd_done,
    input wire logic cmd_nack,
    input wire logic [7:0] cmd_rdata,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic [7:0] cmd_wdata
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 8'h00;
    end

    // One byte per command; idle lines scrambled
    task automatic xfer(input logic w, input logic [7:0] c, d,
        output logic [7:0] r, output logic nk, dn);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_code <= c;
        cmd_wdata <= d;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_write <= ~w;
        cmd_code <= ~c;
        cmd_wdata <= ~d;
        #1;
        r = cmd_rdata;
        nk = cmd_nack;
        dn = cmd_done;
    endtask
endmodule // pcr_host_model

// *** pcr_map.svh ***
`ifndef PCR_MAP_SVH
`define PCR_MAP_SVH

// Command codes
`define PCR_CMD_PAGE 8'h00
`define PCR_CMD_OPER 8'h01
`define PCR_CMD_ONOFF 8'h02
`define PCR_CMD_CLEAR 8'h03
`define PCR_CMD_WPROT 8'h10
`define PCR_CMD_STORE 8'h15
`define PCR_CMD_STATUS 8'h78

// Field positions
`define PCR_PAGE_ALL 7
`define PCR_PAGE_SEL 0
`define PCR_OP_ON 7
`define PCR_OP_MRG_HI 5
`define PCR_OP_MRG_LO 2
`define PCR_CFG_PU 4
`define PCR_CFG_CMD 3
`define PCR_CFG_CPR 2
`define PCR_CFG_POL 1
`define PCR_WP_B7 7
`define PCR_WP_B6 6
`define PCR_WP_B5 5
`define PCR_STS_CML 1
`define PCR_STS_FAULT 4

// Writable bit masks
`define PCR_PAGE_WMASK 8'h81
`define PCR_OP_WMASK 8'hBC
`define PCR_CFG_WMASK 8'h1E
`define PCR_WP_WMASK 8'hE0

// Reset values
`define PCR_PAGE_RST 8'h00
`define PCR_OP_RST 8'h00
`define PCR_CFG_RST 8'h16
`define PCR_WP_RST 8'h00

// Margin codes
`define PCR_MRG_LO_IGN 4'h5
`define PCR_MRG_LO_ACT 4'h6
`define PCR_MRG_HI_IGN 4'h9
`define PCR_MRG_HI_ACT 4'hA

// Output target selects
`define PCR_VSEL_NOM 2'h0
`define PCR_VSEL_LOW 2'h1
`define PCR_VSEL_HIGH 2'h2

`endif

// *** pcr_pkg.sv ***
package pcr_pkg;

    typedef logic [15:0] pcr_dly_t;

    typedef enum logic [1:0] {
        PCR_OFF = 2'h0,
        PCR_RUN = 2'h1,
        PCR_STOP = 2'h3
    } pcr_run_t;

    typedef struct packed {
        pcr_run_t st;
        pcr_dly_t cnt;
        logic latched;
        logic [1:0] vsel;
        logic act_flt;
    } pcr_chan_state_t;

    typedef struct packed {
        logic [1:0] pin_s1;
        logic [1:0] pin_s2;
        logic init;
        logic [7:0] page;
        logic [1:0][7:0] op;
        logic [1:0][7:0] cfg;
        logic [1:0] pol;
        logic [7:0] wp;
        logic [1:0][7:0] sts;
        logic alert;
        logic [7:0] rdata;
        logic done;
        logic nack;
        logic ext_wr;
        logic store;
    } pcr_regs_t;

endpackage

// *** pcr_top.sv ***
`timescale 1ns/10ps
`include "pcr_map.svh"

// Summary of operation
// - Page bits pick first, second or both
// - Page-all without select is discarded
// - Both-channel reads return first channel
// - Read-only bits ignore written data
// - Operation held per channel until changed
// - On bit gates switching, drivers low
// - Margin field decodes off, low, high
// - Margin selects stored low/high setpoint
// - Power-up gating selects pin/command start
// - Command enable honours operation on bit
// - Pin enable requires asserted pin
// - Polarity takes effect only after restore
// - Pin off action fixed: delayed off
// - Clear faults clears status, drops alert
// - Clear faults never restarts latched channel
// - Persisting fault re-sets bit and alerts
// - Reads always allowed
// - Bit5 allows protect, page, operation, config
// - Bit6 allows protect, page, operation
// - Bit7 allows only protect writes
// - Several protect bits: refuse, alert, cml
// - Page bit 7 all, bit 0 select
// - Store-all requests nonvolatile copy
module pcr_top
    import pcr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cmd_wdata,
    output logic [7:0] cmd_rdata,
    output logic cmd_done,
    output logic cmd_nack,
    output logic ext_wr,
    output logic nvm_store,
    input wire logic [1:0][7:0] nvm_cfg_image,
    input wire logic [1:0] channel_enable_pin,
    input wire logic power_ok,
    input wire logic [1:0] fault_active,
    input wire logic [1:0] fault_shutdown,
    input wire pcr_dly_t off_delay,
    output logic [1:0] gate_enable,
    output logic [1:0][1:0] vout_sel,
    output logic [1:0] margin_act_fault,
    output logic alert
);
    pcr_regs_t r_q;
    pcr_regs_t r_d;
    logic wp_allow;
    logic wp_multi;
    logic [1:0] tgt;
    logic rd_idx;
    logic [1:0][7:0] sts_set;
    logic [1:0] run;
    logic [1:0][1:0] vsel;
    logic [1:0] act_flt;
    logic wr;
    logic rd;

    pcr_chan_if chan_bus[2] ();

    // Merge writable bits only
    function automatic logic [7:0] merge(
        input logic [7:0] old,
        input logic [7:0] nw,
        input logic [7:0] mask
    );
        merge = (old & ~mask) | (nw & mask);
    endfunction

    pcr_wp u_wp (
        .wp(r_q.wp),
        .code(cmd_code),
        .wdata(cmd_wdata),
        .allow(wp_allow),
        .multi(wp_multi)
    );

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_chan
            assign chan_bus[g].op = r_q.op[g];
            assign chan_bus[g].cfg = r_q.cfg[g];
            assign chan_bus[g].pol = r_q.pol[g];
            assign chan_bus[g].pin = r_q.pin_s2[g];
            assign chan_bus[g].power_ok = power_ok;
            assign chan_bus[g].fault = fault_active[g];
            assign chan_bus[g].fault_shutdown = fault_shutdown[g];
            assign chan_bus[g].off_delay = off_delay;
            assign run[g] = chan_bus[g].run;
            assign vsel[g] = chan_bus[g].vsel;
            assign act_flt[g] = chan_bus[g].act_flt;

            pcr_chan u_chan (
                .clk(clk),
                .rst(rst),
                .cb(chan_bus[g])
            );
        end
    endgenerate

    always_comb begin
        r_d = r_q;
        wr = cmd_valid & cmd_write;
        rd = cmd_valid & ~cmd_write;

        // Pin synchroniser
        r_d.pin_s1 = channel_enable_pin;
        r_d.pin_s2 = r_q.pin_s1;

        // Page targeting
        if (r_q.page[`PCR_PAGE_ALL]) begin
            tgt = 2'h3;
        end else if (r_q.page[`PCR_PAGE_SEL]) begin
            tgt = 2'h2;
        end else begin
            tgt = 2'h1;
        end
        rd_idx = r_q.page[`PCR_PAGE_SEL]
            & ~r_q.page[`PCR_PAGE_ALL];

        // One-cycle strobes default low
        r_d.done = 1'b0;
        r_d.nack = 1'b0;
        r_d.ext_wr = 1'b0;
        r_d.store = 1'b0;

        // Defaults from nonvolatile image after reset
        r_d.init = 1'b0;
        if (r_q.init) begin
            for (int i = 0; i < 2; i++) begin
                r_d.cfg[i] = merge(`PCR_CFG_RST, nvm_cfg_image[i],
                    `PCR_CFG_WMASK);
                r_d.pol[i] = nvm_cfg_image[i][`PCR_CFG_POL];
            end
        end

        // Fault status, set wins over clear
        for (int i = 0; i < 2; i++) begin
            sts_set[i] = 8'h00;
            sts_set[i][`PCR_STS_FAULT] = fault_active[i];
            sts_set[i][`PCR_STS_CML] = wr & wp_multi;
        end

        if (rd) begin
            r_d.done = 1'b1;
            unique case (cmd_code)
                `PCR_CMD_PAGE: r_d.rdata = r_q.page & `PCR_PAGE_WMASK;
                `PCR_CMD_OPER: r_d.rdata = r_q.op[rd_idx] & `PCR_OP_WMASK;
                `PCR_CMD_ONOFF: r_d.rdata = r_q.cfg[rd_idx] & `PCR_CFG_WMASK;
                `PCR_CMD_WPROT: r_d.rdata = r_q.wp & `PCR_WP_WMASK;
                `PCR_CMD_STATUS: r_d.rdata = r_q.sts[rd_idx];
                default: r_d.rdata = 8'h00;
            endcase
        end

        if (wr) begin
            r_d.done = 1'b1;
            if (!wp_allow || wp_multi) begin
                r_d.nack = 1'b1;
            end else begin
                unique case (cmd_code)
                    `PCR_CMD_PAGE: begin
                        if (!(cmd_wdata[`PCR_PAGE_ALL]
                            && !cmd_wdata[`PCR_PAGE_SEL])) begin
                            r_d.page = merge(r_q.page, cmd_wdata,
                                `PCR_PAGE_WMASK);
                        end
                    end
                    `PCR_CMD_OPER: begin
                        for (int i = 0; i < 2; i++) begin
                            if (tgt[i]) begin
                                r_d.op[i] = merge(r_q.op[i], cmd_wdata,
                                    `PCR_OP_WMASK);
                            end
                        end
                    end
                    `PCR_CMD_ONOFF: begin
                        for (int i = 0; i < 2; i++) begin
                            if (tgt[i]) begin
                                // Polarity in use is not touched here
                                r_d.cfg[i] = merge(r_q.cfg[i], cmd_wdata,
                                    `PCR_CFG_WMASK);
                            end
                        end
                    end
                    `PCR_CMD_CLEAR: begin
                        for (int i = 0; i < 2; i++) begin
                            if (tgt[i]) begin
                                r_d.sts[i] = 8'h00;
                            end
                        end
                    end
                    `PCR_CMD_WPROT: begin
                        r_d.wp = merge(r_q.wp, cmd_wdata,
                            `PCR_WP_WMASK);
                    end
                    `PCR_CMD_STORE: begin
                        r_d.store = 1'b1;
                    end
                    `PCR_CMD_STATUS: begin
                        r_d.nack = 1'b1;
                    end
                    default: begin
                        r_d.ext_wr = 1'b1;
                    end
                endcase
            end
        end

        // Set bits re-applied after any clear
        for (int i = 0; i < 2; i++) begin
            r_d.sts[i] = r_d.sts[i] | sts_set[i];
        end

        // Alert drops on clear, rises on any new status bit
        if (wr && wp_allow && !wp_multi
            && cmd_code == `PCR_CMD_CLEAR) begin
            r_d.alert = |((sts_set[0] & {8{tgt[0]}})
                | (sts_set[1] & {8{tgt[1]}})
                | (r_d.sts[0] & ~{8{tgt[0]}})
                | (r_d.sts[1] & ~{8{tgt[1]}}));
        end else begin
            r_d.alert = r_q.alert
                | (|(r_d.sts[0] & ~r_q.sts[0]))
                | (|(r_d.sts[1] & ~r_q.sts[1]));
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r_q.pin_s1 <= 2'h0;
            r_q.pin_s2 <= 2'h0;
            r_q.init <= 1'b1;
            r_q.page <= `PCR_PAGE_RST;
            r_q.op <= {2{`PCR_OP_RST}};
            r_q.cfg <= {2{`PCR_CFG_RST}};
            r_q.pol <= 2'h3;
            r_q.wp <= `PCR_WP_RST;
            r_q.sts <= {2{8'h00}};
            r_q.alert <= 1'b0;
            r_q.rdata <= 8'h00;
            r_q.done <= 1'b0;
            r_q.nack <= 1'b0;
            r_q.ext_wr <= 1'b0;
            r_q.store <= 1'b0;
        end else begin
            r_q <= r_d;
        end
    end

    assign cmd_rdata = r_q.rdata;
    assign cmd_done = r_q.done;
    assign cmd_nack = r_q.nack;
    assign ext_wr = r_q.ext_wr;
    assign nvm_store = r_q.store;
    assign alert = r_q.alert;
    assign gate_enable = run;
    assign vout_sel = vsel;
    assign margin_act_fault = act_flt;
endmodule // pcr_top

// *** pcr_top_checker.sv ***
`timescale 1ns/10ps

module pcr_top_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cmd_wdata,
    input wire logic [7:0] cmd_rdata,
    input wire logic cmd_done,
    input wire logic cmd_nack,
    input wire logic ext_wr,
    input wire logic alert
);
    logic [7:0] wp_q, wp_d;
    logic wr, one;

    assign wr = cmd_valid && cmd_write;
    assign one = $countones(cmd_wdata & 8'hE0) < 2;

    // Shadow of the protect setting in force
    always_comb begin
        wp_d = wp_q;
        if (wr && cmd_code == 8'h10 && one) begin
            wp_d = cmd_wdata & 8'hE0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_q <= 8'h00;
        end else begin
            wp_q <= wp_d;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    AST_DONE_ONE: assert property (cmd_valid |=> cmd_done)
        else $error("done missing");
    AST_DONE_ONLY: assert property (!cmd_valid |=> !cmd_done && !ext_wr)
        else $error("stray done");
    AST_NACK_DONE: assert property (cmd_nack |-> cmd_done)
        else $error("nack without done");
    AST_READ_FREE: assert property (cmd_valid && !cmd_write |=> !cmd_nack)
        else $error("read refused");
    AST_OP_RO: assert property (cmd_valid && !cmd_write && cmd_code == 8'h01
        |=> (cmd_rdata & 8'h43) == 8'h00)
        else $error("op read-only bits set");
    AST_WP_SELF: assert property (wr && cmd_code == 8'h10 && one |=> !cmd_nack)
        else $error("protect write refused");
    AST_WP_MULTI: assert property (wr && cmd_code == 8'h10 && !one
        |=> cmd_nack ##[1:3] alert)
        else $error("multi-bit protect accepted");
    AST_WP_ALL: assert property (wr && wp_q[7] && cmd_code != 8'h10 |=> cmd_nack)
        else $error("write passed bit7");
    AST_WP_SIX: assert property (wr && wp_q[6] && cmd_code == 8'h02 |=> cmd_nack)
        else $error("config passed bit6");
    AST_WP_FIVE: assert property (wr && wp_q[5] && cmd_code == 8'h02 |=> !cmd_nack)
        else $error("config refused bit5");
    AST_WP_CLR: assert property (wr && wp_q != 8'h00 && cmd_code == 8'h03 |=> cmd_nack)
        else $error("clear passed protect");
    AST_PAGE_BAD: assert property (wr && !wp_q[7] && cmd_code == 8'h00
        && cmd_wdata[7] && !cmd_wdata[0] |=> !cmd_nack)
        else $error("illegal page nacked");

    CV_MULTI: cover property (wr && cmd_code == 8'h10 && !one);
    CV_ALERT: cover property ($rose(alert));
    CV_NACK: cover property (cmd_nack);
endmodule // pcr_top_checker

bind pcr_top pcr_top_checker u_chk (.clk(clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_done(cmd_done),
    .cmd_nack(cmd_nack), .ext_wr(ext_wr), .alert(alert));

// *** pcr_wp.sv ***
`timescale 1ns/10ps
`include "pcr_map.svh"

module pcr_wp (
    input wire logic [7:0] wp,
    input wire logic [7:0] code,
    input wire logic [7:0] wdata,
    output logic allow,
    output logic multi
);
    logic [1:0] cnt;

    always_comb begin
        cnt = 2'(wdata[`PCR_WP_B7]) + 2'(wdata[`PCR_WP_B6])
            + 2'(wdata[`PCR_WP_B5]);
        multi = (code == `PCR_CMD_WPROT) && (cnt > 2'h1);
        if (code == `PCR_CMD_WPROT) begin
            allow = 1'b1;
        end else if (wp[`PCR_WP_B7]) begin
            allow = 1'b0;
        end else if (wp[`PCR_WP_B6]) begin
            allow = (code == `PCR_CMD_PAGE)
                || (code == `PCR_CMD_OPER);
        end else if (wp[`PCR_WP_B5]) begin
            allow = (code == `PCR_CMD_PAGE) || (code == `PCR_CMD_OPER)
                || (code == `PCR_CMD_ONOFF);
        end else begin
            allow = 1'b1;
        end
    end
endmodule // pcr_wp

// *** pmbus_channel_control_regs_tb_top.sv ***
`timescale 1ns/10ps
`include "pcr_map.svh"
`define CHK(n, e, a) begin \
    tests_run++; \
    if ((a) !== (e)) begin \
        num_errors++; \
        $display("BAD %s exp %0h got %0h", n, e, a); \
    end \
end

module pmbus_channel_control_regs_tb_top
    import pcr_pkg::*;
;
    logic clk, rst, cmd_valid, cmd_write, cmd_done, cmd_nack;
    logic ext_wr, nvm_store, alert, pok;
    logic [7:0] cmd_code, cmd_wdata, cmd_rdata, pg;
    logic [1:0][7:0] img;
    logic [1:0] pin, flt, fsd, gate, maf;
    logic [1:0][1:0] vsel;
    pcr_dly_t odly;
    logic [15:0] rnd;
    logic [7:0] mt [5] = '{8'h8C, 8'h94, 8'h98, 8'hA4, 8'hA8};
    int num_errors = 0, tests_run = 0, cyc = 0;

    pcr_top u_dut (.clk, .rst, .cmd_valid, .cmd_write, .cmd_code,
        .cmd_wdata, .cmd_rdata, .cmd_done, .cmd_nack, .ext_wr,
        .nvm_store, .nvm_cfg_image(img), .channel_enable_pin(pin),
        .power_ok(pok), .fault_active(flt), .fault_shutdown(fsd),
        .off_delay(odly), .gate_enable(gate), .vout_sel(vsel),
        .margin_act_fault(maf), .alert);
    pcr_host_model u_host (.clk, .cmd_done, .cmd_nack, .cmd_rdata,
        .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [2:0] mrg(input logic [7:0] op);
        case (op[5:2])
            4'h5: return 3'b001;
            4'h6: return 3'b101;
            4'h9: return 3'b010;
            4'hA: return 3'b110;
            default: return 3'b000;
        endcase
    endfunction

    function automatic logic [7:0] pg_next(input logic [7:0] o, n);
        return (n[7] && !n[0]) ? o : (n & 8'h81);
    endfunction

    task automatic go(input logic w, input logic [7:0] c, d,
        output logic [7:0] r, output logic nk);
        logic dn;
        u_host.xfer(w, c, d, r, nk, dn);
        `CHK("done", 1'b1, dn)
    endtask

    task automatic wr(input logic [7:0] c, d, input logic nk);
        logic [7:0] r;
        logic n;
        go(1'b1, c, d, r, n);
        `CHK("nack", nk, n)
    endtask

    task automatic rd(input logic [7:0] c, e);
        logic [7:0] r;
        logic n;
        go(1'b0, c, 8'h00, r, n);
        `CHK("rdata", e, r)
    endtask

    task automatic wait_cy(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    initial begin
        rst = 1'b1;
        img = {8'h16, 8'h16};
        pin = 2'b00;
        pok = 1'b1;
        flt = 2'b00;
        fsd = 2'b00;
        odly = 16'h0000;
        rnd = 16'h35DF;
        pg = 8'h00;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        wait_cy(2);
        rd(`PCR_CMD_PAGE, 8'h00);
        rd(`PCR_CMD_OPER, 8'h00);
        rd(`PCR_CMD_ONOFF, 8'h16);
        rd(`PCR_CMD_WPROT, 8'h00);
        `CHK("gate", 2'b00, gate)
        @(posedge clk);
        pin <= 2'b11;
        wait_cy(6);
        `CHK("gate", 2'b11, gate)
        wr(`PCR_CMD_ONOFF, 8'h14, 1'b0);
        rd(`PCR_CMD_ONOFF, 8'h14);
        wait_cy(4);
        `CHK("gate", 2'b11, gate)
        pin <= 2'b00;
        wait_cy(6);
        `CHK("gate", 2'b00, gate)
        wr(`PCR_CMD_PAGE, 8'h81, 1'b0);
        wr(`PCR_CMD_ONOFF, 8'h00, 1'b0);
        wait_cy(4);
        `CHK("gate", 2'b11, gate)
        wr(`PCR_CMD_ONOFF, 8'h18, 1'b0);
        wait_cy(4);
        `CHK("gate", 2'b00, gate)
        wr(`PCR_CMD_OPER, 8'h80, 1'b0);
        wait_cy(4);
        `CHK("gate", 2'b11, gate)
        wr(`PCR_CMD_OPER, 8'h00, 1'b0);
        wait_cy(4);
        `CHK("gate", 2'b00, gate)
        wr(`PCR_CMD_PAGE, 8'h80, 1'b0);
        rd(`PCR_CMD_PAGE, 8'h81);
        wr(`PCR_CMD_PAGE, 8'h01, 1'b0);
        wr(`PCR_CMD_OPER, 8'h14, 1'b0);
        wr(`PCR_CMD_PAGE, 8'h81, 1'b0);
        rd(`PCR_CMD_OPER, 8'h00);
        wr(`PCR_CMD_PAGE, 8'h01, 1'b0);
        rd(`PCR_CMD_OPER, 8'h14);
        wr(`PCR_CMD_PAGE, 8'h00, 1'b0);
        foreach (mt[i]) begin
            wr(`PCR_CMD_OPER, mt[i], 1'b0);
            wait_cy(2);
            `CHK("vsel", mrg(mt[i]) & 3'b011, {1'b0, vsel[0]})
            `CHK("act", mrg(mt[i]) >> 2, {2'b00, maf[0]})
        end
        for (int i = 0; i < 24; i++) begin
            rnd = lfsr(rnd);
            wr(`PCR_CMD_OPER, rnd[7:0], 1'b0);
            rd(`PCR_CMD_OPER, rnd[7:0] & 8'hBC);
            wr(`PCR_CMD_PAGE, rnd[15:8], 1'b0);
            pg = pg_next(pg, rnd[15:8]);
            rd(`PCR_CMD_PAGE, pg);
        end
        wr(`PCR_CMD_PAGE, 8'h81, 1'b0);
        wr(`PCR_CMD_OPER, 8'h00, 1'b0);
        wr(`PCR_CMD_WPROT, 8'h20, 1'b0);
        wr(`PCR_CMD_ONOFF, 8'h18, 1'b0);
        wr(`PCR_CMD_CLEAR, 8'h00, 1'b1);
        wr(`PCR_CMD_WPROT, 8'h40, 1'b0);
        wr(`PCR_CMD_ONOFF, 8'h16, 1'b1);
        wr(`PCR_CMD_OPER, 8'h00, 1'b0);
        wr(`PCR_CMD_WPROT, 8'h80, 1'b0);
        wr(`PCR_CMD_OPER, 8'h80, 1'b1);
        wr(`PCR_CMD_PAGE, 8'h00, 1'b1);
        rd(`PCR_CMD_ONOFF, 8'h18);
        rd(`PCR_CMD_OPER, 8'h00);
        wr(`PCR_CMD_WPROT, 8'hA0, 1'b1);
        rd(`PCR_CMD_WPROT, 8'h80);
        `CHK("alert", 1'b1, alert)
        rd(`PCR_CMD_STATUS, 8'h02);
        wr(`PCR_CMD_STORE, 8'h00, 1'b1);
        `CHK("store", 1'b0, nvm_store)
        wr(`PCR_CMD_WPROT, 8'h00, 1'b0);
        wr(`PCR_CMD_STORE, 8'h00, 1'b0);
        `CHK("store", 1'b1, nvm_store)
        wr(8'hD0, 8'h5A, 1'b0);
        `CHK("ext_wr", 1'b1, ext_wr)
        wr(`PCR_CMD_CLEAR, 8'h00, 1'b0);
        `CHK("ext_wr", 1'b0, ext_wr)
        wait_cy(2);
        `CHK("alert", 1'b0, alert)
        rd(`PCR_CMD_STATUS, 8'h00);
        @(posedge clk);
        flt <= 2'b01;
        wait_cy(3);
        wr(`PCR_CMD_CLEAR, 8'h00, 1'b0);
        rd(`PCR_CMD_STATUS, 8'h10);
        `CHK("alert", 1'b1, alert)
        flt <= 2'b00;
        wr(`PCR_CMD_CLEAR, 8'h00, 1'b0);
        rd(`PCR_CMD_STATUS, 8'h00);
        wr(`PCR_CMD_OPER, 8'h80, 1'b0);
        wait_cy(4);
        `CHK("gate", 2'b11, gate)
        fsd <= 2'b01;
        @(posedge clk);
        fsd <= 2'b00;
        wait_cy(3);
        `CHK("gate", 2'b10, gate)
        wr(`PCR_CMD_CLEAR, 8'h00, 1'b0);
        wait_cy(4);
        `CHK("gate", 2'b10, gate)
        tally_and_finish();
    end
endmodule // pmbus_channel_control_regs_tb_top
